// *** pxc_pkg.sv ***
// Package for the port extended control and test packet generator block.
// Assumes a 16-bit management register port with 5-bit register addresses.
package pxc_pkg;
  localparam logic [4:0]  ADDR_EXT_CONTROL_THREE   = 5'h14;
  localparam logic [4:0]  ADDR_INLINE_POWER_CRC    = 5'h17;
  localparam logic [4:0]  ADDR_PKT_GEN_CONTROL     = 5'h1d;
  localparam logic [4:0]  ADDR_PKT_GEN_PATTERN     = 5'h1e;
  localparam logic [15:0] RST_EXT_CONTROL_THREE    = 16'h0004;
  localparam logic [15:0] RST_PKT_GEN_CONTROL      = 16'h0040;
  localparam logic [15:0] RST_PKT_GEN_PATTERN      = 16'h0000;
  localparam int          BIT_ADDR_REVERSE         = 9;
  localparam int          BIT_NO_PREAMBLE          = 5;
  localparam int          BIT_DOWNSHIFT_EN         = 4;
  localparam int          BIT_DOWNSHIFT_STATUS     = 1;
  localparam int          BIT_DETECT_EN            = 10;
  localparam int          BIT_GEN_ENABLE           = 15;
  localparam int          BIT_GEN_RUN              = 14;
  localparam int          BIT_GEN_CONTINUOUS       = 13;
  localparam int          BIT_GEN_RANDOM           = 1;
  localparam int          BIT_GEN_BAD_FCS          = 0;
  localparam logic [1:0]  MEDIA_NONE               = 2'h0;
  localparam logic [1:0]  MEDIA_COPPER             = 2'h1;
  localparam logic [1:0]  DETECT_SEARCHING         = 2'h0;
  localparam logic [1:0]  DETECT_NEEDS_POWER       = 2'h1;
  localparam logic [1:0]  DETECT_NO_POWER          = 2'h2;
  localparam logic [7:0]  CRC_ERR_MAX              = 8'hff;
  localparam logic [2:0]  DOWNSHIFT_BASE           = 3'h2;
  localparam logic [1:0]  PORT_LAST                = 2'h3;
  localparam logic [13:0] LEN_125                  = 14'h007d;
  localparam logic [13:0] LEN_64                   = 14'h0040;
  localparam logic [13:0] LEN_1518                 = 14'h05ee;
  localparam logic [13:0] LEN_JUMBO                = 14'h2710;
  localparam int          PKTS_SINGLE_RUN          = 30000000;
  localparam int          PKTS_INCREMENT           = 10000;
  localparam logic [43:0] DEST_ADDR_UPPER          = 44'hfff_ffff_ffff;
  localparam logic [43:0] SRC_ADDR_UPPER           = 44'hfff_ffff_ffff;
  localparam logic [15:0] LFSR_SEED                = 16'hace1;
  localparam logic [15:0] LFSR_TAPS                = 16'hb400;
endpackage

// *** pxc_gen_if.sv ***
// Interface carrying the latched generator settings and the generator status.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface pxc_gen_if;
  logic        start;
  logic        stop;
  logic        continuous;
  logic [13:0] frame_len;
  logic        random;
  logic        bad_fcs;
  logic [15:0] pattern;
  logic        busy;
  logic        pkt_done;
  modport ctrl (output start, output stop, output continuous, output frame_len,
                output random, output bad_fcs, output pattern,
                input busy, input pkt_done);
  modport gen  (input start, input stop, input continuous, input frame_len,
                input random, input bad_fcs, input pattern,
                output busy, output pkt_done);
endinterface

// *** pxc_frame_gen.sv ***
// Byte engine that emits generated test frames.
// Assumes settings other than the continuous bit are stable for the whole run; the control block latches them.
`timescale 1ns/1ps
module pxc_frame_gen
  import pxc_pkg::*;
#(
  parameter int PKTS_TOTAL = PKTS_SINGLE_RUN,
  parameter int PKTS_STEP  = PKTS_INCREMENT
)(
  input  wire logic i_mclk,
  input  wire logic i_rst,
  pxc_gen_if.gen    gen,
  input  wire logic [7:0] i_hdr_byte,
  output logic      [5:0] o_hdr_idx,
  output logic      [7:0] o_tx_data,
  output logic            o_tx_en
);
  logic [13:0] byte_cnt;
  logic [31:0] pkt_cnt;
  logic [31:0] step_cnt;
  logic [15:0] lfsr;
  logic        stopping;
  logic        last_byte;
  logic        in_fcs;
  logic        hdr_zone;
  logic [7:0]  pat_byte;
  logic [7:0]  pay_byte;
  logic [7:0]  fcs_byte;
  logic        run_done;

  // Byte selection for the current position of the frame.
  assign last_byte = (byte_cnt == gen.frame_len - 14'h0001);
  assign in_fcs    = (byte_cnt >= gen.frame_len - 14'h0004);
  assign hdr_zone  = (byte_cnt < 14'h000c);
  assign o_hdr_idx = byte_cnt[5:0];
  assign pat_byte  = byte_cnt[0] ? gen.pattern[7:0] : gen.pattern[15:8];
  assign pay_byte  = gen.random ? lfsr[7:0] : pat_byte;
  assign fcs_byte  = gen.bad_fcs ? ~lfsr[15:8] : lfsr[15:8];
  assign run_done  = (!gen.continuous && pkt_cnt == PKTS_TOTAL - 1) ||
                     (stopping && step_cnt == PKTS_STEP - 1);
  assign gen.pkt_done = gen.busy && last_byte;

  // Frame sequencer and packet counters.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || gen.start)
    begin
      gen.busy  <= gen.start;
      byte_cnt  <= 14'h0000;
      pkt_cnt   <= 32'h0;
      step_cnt  <= 32'h0;
      stopping  <= 1'b0;
      lfsr      <= LFSR_SEED;
      o_tx_en   <= 1'b0;
      o_tx_data <= 8'h00;
    end
    else
    begin
      o_tx_en   <= gen.busy;
      o_tx_data <= hdr_zone ? i_hdr_byte : (in_fcs ? fcs_byte : pay_byte);
      if (gen.stop)
        stopping <= 1'b1;
      if (gen.busy)
      begin
        lfsr     <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
        byte_cnt <= last_byte ? 14'h0000 : byte_cnt + 14'h0001;
        if (last_byte)
        begin
          pkt_cnt  <= pkt_cnt + 32'h1;
          step_cnt <= (step_cnt == PKTS_STEP - 1) ? 32'h0 : step_cnt + 32'h1;
          if (run_done)
            gen.busy <= 1'b0;
        end
      end
    end
  end
endmodule

// *** pxc_crc_counter.sv ***
// Saturating receive CRC error counter that clears when read.
// Assumes error pulses are one cycle wide and synchronous.
`timescale 1ns/1ps
module pxc_crc_counter
  import pxc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_crc_err,
  input  wire logic       i_clear,
  output logic      [7:0] o_count
);
  logic at_max;
  assign at_max = (o_count == CRC_ERR_MAX);

  // A read clears; an error in that same cycle starts the new count at one.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      o_count <= 8'h00;
    else if (i_clear)
      o_count <= i_crc_err ? 8'h01 : 8'h00;
    else if (i_crc_err && !at_max)
      o_count <= o_count + 8'h01;
  end
endmodule

// *** pxc_ext_regs.sv ***
// Extended register page block: control 3 low fields, inline power and CRC
// errors, and the two test packet generator registers with the frame engine.
// Assumes a 16-bit management port, one clock, and an external port index strap.
// How it works
// - Reversal maps port n to address 3-n.
// - Media status reads 00 none, 01 copper.
// - No-preamble bit lets receiver raise data valid.
// - Downshift enable allows gigabit fallback after failures.
// - Threshold codes give 2,3,4,5 failures; default 01.
// - Downshift status reads one when required.
// - Management address latched at reset, read-only.
// - Detection status valid only with detection enabled.
// - Detection codes: searching, needs power, no power.
// - CRC error counter saturates, clears on read.
// - Single run stops at total; continuous stops on step.
// - Length codes give 125, 64, 1518, 10000 bytes.
// - Destination address all ones with programmed nibble.
// - Source address low nibble from field.
// - Payload type picks random or fixed pattern.
// - FCS bit picks corrupted or correct check.
// - Pattern repeats through payload; resets to zero.
// - Control changes apply only after run toggle, except clearing continuous, which applies at once.
// - Pattern changes apply only after run toggle.
`timescale 1ns/1ps
module pxc_ext_regs
  import pxc_pkg::*;
#(
  parameter int PKTS_TOTAL = PKTS_SINGLE_RUN,
  parameter int PKTS_STEP  = PKTS_INCREMENT
)(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_soft_rst,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [1:0]  i_port_idx,
  input  wire logic [4:0]  i_base_addr,
  input  wire logic        i_copper_sel,
  input  wire logic        i_gig_an_fail,
  input  wire logic        i_an_restart,
  input  wire logic        i_detect_needs_power,
  input  wire logic        i_detect_no_power,
  input  wire logic        i_crc_err,
  input  wire logic        i_rx_data_seen,
  input  wire logic        i_rx_sfd_seen,
  output logic             o_rx_dv_permit,
  output logic      [1:0]  o_mgmt_port,
  output logic      [4:0]  o_phy_addr,
  output logic             o_downshift,
  output logic             o_detect_en,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_en,
  output logic             o_gen_busy
);
  pxc_gen_if gif ();

  logic        addr_reverse;
  logic        no_preamble;
  logic        downshift_en;
  logic [1:0]  downshift_thr;
  logic        downshift_st;
  logic [2:0]  fail_cnt;
  logic        detect_en;
  logic [1:0]  detect_st;
  logic [4:0]  phy_addr;
  logic        addr_latched;
  logic [15:0] gen_ctrl;
  logic [15:0] gen_pat;
  logic        run_prev;
  logic [13:0] lat_ctrl;
  logic [15:0] lat_pat;
  logic [7:0]  crc_count;
  logic [15:0] rd_mux;
  logic        sel_ec3;
  logic        sel_ipc;
  logic        sel_gc;
  logic        sel_gp;
  logic        sticky_clr;
  logic [2:0]  fail_limit;
  logic        run_rise;
  logic        run_fall;
  logic [1:0]  media_st;
  logic [47:0] dest_addr;
  logic [47:0] src_addr;
  logic [5:0]  hdr_idx;
  logic [7:0]  hdr_byte;
  logic [95:0] hdr_bits;

  // Address decode of the four registers.
  assign sel_ec3    = (i_addr == ADDR_EXT_CONTROL_THREE);
  assign sel_ipc    = (i_addr == ADDR_INLINE_POWER_CRC);
  assign sel_gc     = (i_addr == ADDR_PKT_GEN_CONTROL);
  assign sel_gp     = (i_addr == ADDR_PKT_GEN_PATTERN);
  assign sticky_clr = i_rst;

  // Port to management address mapping, reversed on request.
  assign o_mgmt_port = addr_reverse ? (PORT_LAST - i_port_idx) : i_port_idx;
  assign o_phy_addr  = phy_addr;

  // Media status follows the copper selection.
  assign media_st = i_copper_sel ? MEDIA_COPPER : MEDIA_NONE;

  // Receiver may raise data valid on data alone when preamble is optional.
  assign o_rx_dv_permit = i_rx_data_seen && (no_preamble || i_rx_sfd_seen);

  // Threshold field maps to a failure count of two through five.
  assign fail_limit  = DOWNSHIFT_BASE + {1'b0, downshift_thr};
  assign o_downshift = downshift_st;
  assign o_detect_en = detect_en;

  // Run bit edges, used to apply latched settings.
  assign run_rise  = gen_ctrl[BIT_GEN_RUN] && !run_prev;
  assign run_fall  = !gen_ctrl[BIT_GEN_RUN] && run_prev;
  assign gif.start = run_rise && gen_ctrl[BIT_GEN_ENABLE];
  assign gif.stop  = run_fall || !lat_ctrl[BIT_GEN_CONTINUOUS] == 1'b0 &&
                     sel_gc && i_wr && !i_wdata[BIT_GEN_CONTINUOUS];
  assign gif.continuous = lat_ctrl[BIT_GEN_CONTINUOUS];
  assign gif.random     = lat_ctrl[BIT_GEN_RANDOM];
  assign gif.bad_fcs    = lat_ctrl[BIT_GEN_BAD_FCS];
  assign gif.pattern    = lat_pat;
  assign gif.frame_len  = (lat_ctrl[12:11] == 2'h0) ? LEN_125 :
                          (lat_ctrl[12:11] == 2'h1) ? LEN_64 :
                          (lat_ctrl[12:11] == 2'h2) ? LEN_1518 : LEN_JUMBO;
  assign o_gen_busy     = gif.busy;

  // Header bytes: destination then source address, most significant first.
  assign dest_addr = {DEST_ADDR_UPPER, lat_ctrl[9:6]};
  assign src_addr  = {SRC_ADDR_UPPER, lat_ctrl[5:2]};
  assign hdr_bits  = {dest_addr, src_addr};
  assign hdr_byte  = hdr_bits[8'd95 - {hdr_idx[3:0], 3'h0} -: 8];

  // Read data assembly; unmapped addresses read as zero.
  assign rd_mux = sel_ec3 ? {6'h00, addr_reverse, 1'b0, media_st, no_preamble,
                             downshift_en, downshift_thr, downshift_st, 1'b0} :
                  sel_ipc ? {phy_addr, detect_en, detect_st, crc_count} :
                  sel_gc  ? gen_ctrl :
                  sel_gp  ? gen_pat : 16'h0000;

  // Read data register, valid the cycle after the read strobe.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else
      o_rdata <= i_rd ? rd_mux : 16'h0000;
  end

  // Sticky control 3 fields: only a hard reset restores their defaults, except reversal, which soft reset also restores.
  always_ff @(posedge i_mclk)
  begin
    if (sticky_clr)
    begin
      addr_reverse  <= RST_EXT_CONTROL_THREE[BIT_ADDR_REVERSE];
      no_preamble   <= RST_EXT_CONTROL_THREE[BIT_NO_PREAMBLE];
      downshift_en  <= RST_EXT_CONTROL_THREE[BIT_DOWNSHIFT_EN];
      downshift_thr <= RST_EXT_CONTROL_THREE[3:2];
      detect_en     <= 1'b0;
    end
    else
    begin
      if (i_soft_rst)
        addr_reverse <= RST_EXT_CONTROL_THREE[BIT_ADDR_REVERSE];
      else if (i_wr && sel_ec3)
        addr_reverse <= i_wdata[BIT_ADDR_REVERSE];
      if (i_wr && sel_ec3)
      begin
        no_preamble   <= i_wdata[BIT_NO_PREAMBLE];
        downshift_en  <= i_wdata[BIT_DOWNSHIFT_EN];
        downshift_thr <= i_wdata[3:2];
      end
      if (i_wr && sel_ipc)
        detect_en <= i_wdata[BIT_DETECT_EN];
    end
  end

  // Gigabit negotiation failure count and downshift status.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || i_soft_rst)
    begin
      fail_cnt     <= 3'h0;
      downshift_st <= 1'b0;
    end
    else if (!downshift_en || i_an_restart)
    begin
      fail_cnt     <= 3'h0;
      downshift_st <= 1'b0;
    end
    else if (i_gig_an_fail && !downshift_st)
    begin
      fail_cnt <= fail_cnt + 3'h1;
      if (fail_cnt + 3'h1 >= fail_limit)
        downshift_st <= 1'b1;
    end
  end

  // Management address capture just after reset release.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      addr_latched <= 1'b0;
      phy_addr     <= 5'h00;
    end
    else if (!addr_latched)
    begin
      addr_latched <= 1'b1;
      phy_addr     <= i_base_addr;
    end
  end

  // Inline power detection status, held at searching while disabled.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !detect_en)
      detect_st <= DETECT_SEARCHING;
    else if (i_detect_needs_power)
      detect_st <= DETECT_NEEDS_POWER;
    else if (i_detect_no_power)
      detect_st <= DETECT_NO_POWER;
  end

  // Generator registers and the settings latched on each start.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || i_soft_rst)
    begin
      gen_ctrl <= RST_PKT_GEN_CONTROL;
      gen_pat  <= RST_PKT_GEN_PATTERN;
      run_prev <= 1'b0;
      lat_ctrl <= RST_PKT_GEN_CONTROL[13:0];
      lat_pat  <= RST_PKT_GEN_PATTERN;
    end
    else
    begin
      run_prev <= gen_ctrl[BIT_GEN_RUN];
      if (i_wr && sel_gc)
        gen_ctrl <= i_wdata;
      if (i_wr && sel_gp)
        gen_pat <= i_wdata;
      if (run_rise)
      begin
        lat_ctrl <= gen_ctrl[13:0];
        lat_pat  <= gen_pat;
      end
      else if (i_wr && sel_gc)
        lat_ctrl[BIT_GEN_CONTINUOUS] <= lat_ctrl[BIT_GEN_CONTINUOUS] &
                                        i_wdata[BIT_GEN_CONTINUOUS];
    end
  end

  // CRC error counter, cleared by a read of its register.
  pxc_crc_counter u_crc (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_crc_err (i_crc_err),
    .i_clear   (i_rd && sel_ipc),
    .o_count   (crc_count)
  );

  // Frame engine fed with the latched settings.
  pxc_frame_gen #(
    .PKTS_TOTAL (PKTS_TOTAL),
    .PKTS_STEP  (PKTS_STEP)
  ) u_gen (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .gen        (gif),
    .i_hdr_byte (hdr_byte),
    .o_hdr_idx  (hdr_idx),
    .o_tx_data  (o_tx_data),
    .o_tx_en    (o_tx_en)
  );
endmodule

// *** pxc_ext_regs_sva.sv ***
// Checker for the extended register block: bus timing, strap, mapping, generator start.
// Assumes pxc_pkg is compiled first and that only the block's ports are visible.
`timescale 1ns/1ps
module pxc_ext_regs_sva
  import pxc_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_soft_rst,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [1:0]  i_port_idx,
  input wire logic [4:0]  i_base_addr,
  input wire logic        i_gig_an_fail,
  input wire logic        i_crc_err,
  input wire logic        i_rx_data_seen,
  input wire logic        i_rx_sfd_seen,
  input wire logic        o_rx_dv_permit,
  input wire logic [1:0]  o_mgmt_port,
  input wire logic [4:0]  o_phy_addr,
  input wire logic        o_downshift,
  input wire logic        o_detect_en,
  input wire logic        o_tx_en,
  input wire logic        o_gen_busy
);
  // Register access decodes.
  wire logic wr_ec3 = i_wr && (i_addr == ADDR_EXT_CONTROL_THREE);
  wire logic wr_ctl = i_wr && (i_addr == ADDR_PKT_GEN_CONTROL);
  wire logic rd_crc = i_rd && (i_addr == ADDR_INLINE_POWER_CRC);
  logic      rev;
  logic      run;
  logic      nopre;
  // Shadows: reversal and run clear on soft reset, the no-preamble bit is sticky.
  always_ff @(posedge i_mclk)
  begin
    rev   <= (i_rst || i_soft_rst) ? 1'b0 : (wr_ec3 ? i_wdata[BIT_ADDR_REVERSE] : rev);
    run   <= (i_rst || i_soft_rst) ? 1'b0 : (wr_ctl ? i_wdata[BIT_GEN_RUN] : run);
    nopre <= i_rst ? 1'b0 : (wr_ec3 ? i_wdata[BIT_NO_PREAMBLE] : nopre);
  end
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  chk_rev_map: assert property (
    o_mgmt_port == (rev ? 2'(PORT_LAST - i_port_idx) : i_port_idx))
    else $error("management port mapping wrong");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its cycle");
  chk_crc_clear: assert property (
    rd_crc && !i_crc_err ##1 !i_crc_err ##1 rd_crc |=> o_rdata[7:0] == 8'h00)
    else $error("error counter not cleared by read");
  chk_addr_latch: assert property ($past(i_rst) |=> o_phy_addr == $past(i_base_addr))
    else $error("address strap not captured");
  chk_addr_hold: assert property (!$past(i_rst) && !$past(i_rst, 2) |-> $stable(o_phy_addr))
    else $error("captured address changed");
  chk_rx_permit: assert property (
    o_rx_dv_permit == (i_rx_data_seen && (nopre || i_rx_sfd_seen)))
    else $error("data valid permit wrong");
  chk_ds_cause: assert property ($rose(o_downshift) |-> $past(i_gig_an_fail))
    else $error("downshift without a failure");
  chk_detect_en: assert property (
    i_wr && i_addr == ADDR_INLINE_POWER_CRC |=> o_detect_en == $past(i_wdata[BIT_DETECT_EN]))
    else $error("detection enable not following write");
  chk_gen_start: assert property (
    wr_ctl && i_wdata[BIT_GEN_ENABLE] && i_wdata[BIT_GEN_RUN] && !run && !o_gen_busy
    |-> ##[2:3] o_tx_en) else $error("generator did not start");
  chk_start_cause: assert property (
    $rose(o_tx_en) |-> $past(wr_ctl, 2) || $past(wr_ctl, 3))
    else $error("generator started without a write");
  cover property ($rose(o_downshift));
  cover property (rd_crc ##1 o_rdata[7:0] == CRC_ERR_MAX);
  cover property ($fell(o_tx_en));
endmodule

bind pxc_ext_regs pxc_ext_regs_sva chk_u (.i_mclk, .i_rst, .i_soft_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_port_idx, .i_base_addr, .i_gig_an_fail, .i_crc_err,
  .i_rx_data_seen, .i_rx_sfd_seen, .o_rx_dv_permit, .o_mgmt_port, .o_phy_addr,
  .o_downshift, .o_detect_en, .o_tx_en, .o_gen_busy);

// *** testbench.sv ***
// Self-checking testbench for the extended register page block.
// Assumes the package, interface, design and checker files are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module testbench
  import pxc_pkg::*;
;
  localparam int PTOT = 6;
  localparam int PSTEP = 2;
  localparam int LENS [4] = '{125, 64, 1518, 10000};
  logic        i_mclk, i_rst, i_soft_rst, i_wr, i_rd, i_copper_sel, i_gig_an_fail;
  logic        i_an_restart, i_detect_needs_power, i_detect_no_power, i_crc_err;
  logic        i_rx_data_seen, i_rx_sfd_seen, o_rx_dv_permit, o_downshift, o_detect_en;
  logic        o_tx_en, o_gen_busy;
  logic [1:0]  i_port_idx, o_mgmt_port;
  logic [4:0]  i_addr, i_base_addr, o_phy_addr;
  logic [7:0]  o_tx_data;
  logic [15:0] i_wdata, o_rdata;
  int          error_cnt = 0;
  int          cmp_count = 0;
  pxc_ext_regs #(.PKTS_TOTAL(PTOT), .PKTS_STEP(PSTEP)) dut_u (.i_mclk, .i_rst, .i_soft_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_port_idx, .i_base_addr, .i_copper_sel,
    .i_gig_an_fail, .i_an_restart, .i_detect_needs_power, .i_detect_no_power, .i_crc_err,
    .i_rx_data_seen, .i_rx_sfd_seen, .o_rx_dv_permit, .o_mgmt_port, .o_phy_addr,
    .o_downshift, .o_detect_en, .o_tx_data, .o_tx_en, .o_gen_busy);
  // Free-running 100 MHz clock.
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Bus write and read; read data is taken in the cycle after the strobe.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Holds one event input high for n cycles: 0 fail, 1 CRC error, 2 restart, 3 soft reset.
  task automatic strobe(input int k, input int n);
    @(posedge i_mclk);
    {i_soft_rst, i_an_restart, i_crc_err, i_gig_an_fail} <= 4'b0001 << k;
    repeat (n) @(posedge i_mclk);
    {i_soft_rst, i_an_restart, i_crc_err, i_gig_an_fail} <= 4'b0000;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic t_reset;
    logic [15:0] d;
    rd(ADDR_EXT_CONTROL_THREE, d);
    `CHK(d, RST_EXT_CONTROL_THREE)
    rd(ADDR_PKT_GEN_CONTROL, d);
    `CHK(d, RST_PKT_GEN_CONTROL)
    rd(ADDR_PKT_GEN_PATTERN, d);
    `CHK(d, RST_PKT_GEN_PATTERN)
    rd(ADDR_INLINE_POWER_CRC, d);
    `CHK(d, 16'ha800)
    i_base_addr <= 5'h0a;
    wr(5'h00, 16'hffff);
    rd(5'h00, d);
    `CHK({d, o_phy_addr}, 21'h000015)
  endtask
  task automatic t_ext3;
    logic [15:0] d;
    i_copper_sel   <= 1'b1;
    i_rx_data_seen <= 1'b1;
    wr(ADDR_EXT_CONTROL_THREE, 16'h0222);
    rd(ADDR_EXT_CONTROL_THREE, d);
    `CHK(d, 16'h0260)
    `CHK(o_rx_dv_permit, 1'b1)
    for (int p = 0; p < 4; p++)
    begin
      i_port_idx <= p[1:0];
      @(posedge i_mclk);
      #1;
      `CHK(o_mgmt_port, 2'(3 - p))
    end
    wr(ADDR_EXT_CONTROL_THREE, 16'h0020);
    i_port_idx <= 2'h0;
    wr(ADDR_EXT_CONTROL_THREE, 16'h023c);
    strobe(3, 1);
    rd(ADDR_EXT_CONTROL_THREE, d);
    `CHK(d, 16'h007c)
    `CHK(o_mgmt_port, 2'h0)
  endtask
  task automatic t_ds;
    logic [15:0] d;
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_EXT_CONTROL_THREE, {12'h001, c[1:0], 2'b00});
      strobe(2, 1);
      strobe(0, c + 1);
      `CHK(o_downshift, 1'b0)
      strobe(0, 1);
      rd(ADDR_EXT_CONTROL_THREE, d);
      `CHK({o_downshift, d[BIT_DOWNSHIFT_STATUS]}, 2'b11)
    end
    wr(ADDR_EXT_CONTROL_THREE, 16'h000c);
    strobe(2, 1);
    strobe(0, 6);
    `CHK(o_downshift, 1'b0)
  endtask
  task automatic t_poe;
    logic [15:0] d;
    logic [1:0]  e;
    {i_rx_data_seen, i_rx_sfd_seen} <= 2'b11;
    wr(ADDR_INLINE_POWER_CRC, 16'hfcff);
    for (int k = 0; k < 4; k++)
    begin
      {i_detect_needs_power, i_detect_no_power} <= k[1:0];
      e = k[1] ? DETECT_NEEDS_POWER : (k[0] ? DETECT_NO_POWER : DETECT_SEARCHING);
      rd(ADDR_INLINE_POWER_CRC, d);
      `CHK(d[15:8], {5'h15, 1'b1, e})
    end
    `CHK({o_detect_en, o_rx_dv_permit}, 2'b11)
    strobe(1, 3);
    rd(ADDR_INLINE_POWER_CRC, d);
    `CHK(d[7:0], 8'h03)
    rd(ADDR_INLINE_POWER_CRC, d);
    `CHK(d[7:0], 8'h00)
    strobe(1, 300);
    rd(ADDR_INLINE_POWER_CRC, d);
    `CHK(d[7:0], CRC_ERR_MAX)
    wr(ADDR_INLINE_POWER_CRC, 16'h0000);
    rd(ADDR_INLINE_POWER_CRC, d);
    `CHK({o_detect_en, d[10], d[7:0]}, 10'h000)
  endtask
  // Starts a run by toggling run, checks header and fixed payload bytes and the run length; mid stops continuous.
  task automatic gen_run(input logic [15:0] c, input logic [15:0] p, input bit mid,
                         output logic [31:0] fcs, output int mis);
    int         len;
    int         cnt;
    int         i;
    logic [7:0] e;
    len = LENS[c[12:11]];
    cnt = 0;
    mis = 0;
    wr(ADDR_PKT_GEN_PATTERN, p);
    wr(ADDR_PKT_GEN_CONTROL, c & 16'hbfff);
    wr(ADDR_PKT_GEN_CONTROL, c);
    fork
      begin
        for (i = 0; i < 6 && o_tx_en !== 1'b1; i++)
        begin
          @(posedge i_mclk);
          #1;
        end
        `CHK(o_tx_en, 1'b1)
        while (o_tx_en === 1'b1 && cnt < 70000)
        begin
          i = cnt % len;
          e = (i == 5) ? {4'hf, c[9:6]} : (i == 11) ? {4'hf, c[5:2]} :
              (i < 12) ? 8'hff : i[0] ? p[7:0] : p[15:8];
          if (i >= len - 4)
            fcs = {fcs[23:0], o_tx_data};
          else if (i >= 12 && c[BIT_GEN_RANDOM])
            mis += (o_tx_data != e);
          else
            `CHK(o_tx_data, e)
          cnt++;
          @(posedge i_mclk);
          #1;
        end
      end
      if (mid)
      begin
        repeat (10) @(posedge i_mclk);
        wr(ADDR_PKT_GEN_PATTERN, ~p);
        wr(ADDR_PKT_GEN_CONTROL, (c & 16'hdfff) ^ 16'h0040);
      end
    join
    @(posedge i_mclk);
    #1;
    `CHK(cnt, len * (mid ? PSTEP : PTOT))
    `CHK(o_gen_busy, 1'b0)
  endtask
  task automatic t_gen;
    logic [31:0] f1;
    logic [31:0] f2;
    int          m;
    i_rx_data_seen <= 1'b0;
    gen_run(16'hc168, 16'ha55a, 1'b0, f1, m);
    gen_run(16'hd168, 16'h00ff, 1'b0, f1, m);
    gen_run(16'hc968, 16'h1234, 1'b0, f1, m);
    gen_run(16'hc969, 16'h1234, 1'b0, f2, m);
    `CHK(f2, ~f1)
    gen_run(16'hc96a, 16'h1234, 1'b0, f1, m);
    `CHK(m > 0, 1'b1)
    gen_run(16'hf968, 16'h5aa5, 1'b1, f1, m);
  endtask
  task automatic t_hard;
    logic [15:0] d;
    wr(ADDR_EXT_CONTROL_THREE, 16'h0030);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(ADDR_EXT_CONTROL_THREE, d);
    `CHK(d, RST_EXT_CONTROL_THREE | 16'h0040)
    `CHK(o_phy_addr, 5'h0a)
    {i_rx_data_seen, i_rx_sfd_seen} <= 2'b10;
    @(posedge i_mclk);
    #1;
    `CHK(o_rx_dv_permit, 1'b0)
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short after roughly three times the expected run length.
  initial
  begin
    #1_000_000;
    error_cnt++;
    wrap_up();
  end
  // Main sequence: reset for 12 cycles, then the scenarios in turn.
  initial
  begin
    {i_rst, i_soft_rst, i_wr, i_rd, i_copper_sel, i_gig_an_fail, i_an_restart} = 7'h40;
    {i_detect_needs_power, i_detect_no_power, i_crc_err, i_rx_data_seen} = 4'h0;
    i_rx_sfd_seen = 1'b0;
    i_addr        = 5'h00;
    i_wdata       = 16'h0000;
    i_port_idx    = 2'h0;
    i_base_addr   = 5'h15;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_ext3();
    t_ds();
    t_poe();
    t_gen();
    t_hard();
    wrap_up();
  end
endmodule
